// *** verilog/fitc_pkg.sv ***
// constants for the fifo, interrupt, timer and crc support core
// Operation
// - crc starts from preset 0000h, 6363h, A671h or FFFFh by two-bit field
// - crc is 16 bits with polynomial x^16 + x^12 + x^5 + 1
// - bit-order bit set takes each byte msb first, else lsb first
// - one shared byte-wide fifo of 64 entries for host and core
// - host write pushes a byte; host read returns byte and advances read pointer
// - seven-bit level field reports bytes stored between the pointers
// - flush resets both pointers, zeroes level and clears overflow flag
// - overflow flag stays set until the host flushes the fifo
// - almost full when 64 minus level <= watermark; almost empty when level <= watermark
// - each enabled flag sets the global interrupt status and the irq pin
// - timer flag set when the counter decrements from 1 to 0
// - transmit-done flag set when transmitter moves from data to end of frame
// - crc-done flag set once all fifo data is processed and crc ready reads 1
// - receive-done flag on end of data; idle flag when command returns to idle
// - almost-full and almost-empty flags set when the alert rises, six-bit watermark
// - error flag set whenever any error status bit is 1
// - timer clock 6.78 MHz feeds a 12-bit prescaler split 4 high, 8 low
// - counter reloads from 16-bit host value; count readable by host
// - at zero timer stops or restarts; host can set and clear timer flag
// - start-now and stop-now bits, running status, automatic start in auto mode
// - prescaler divides by value plus one; counter flags after reload steps, then reload plus one per restart
// - timer expiry changes no other operation
package fitc_pkg;
  localparam int FIFO_DEPTH = 64;
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_IEN = 8'h04;
  localparam logic [7:0] A_IFL = 8'h08;
  localparam logic [7:0] A_IFM = 8'h0C;
  localparam logic [7:0] A_ERR = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_FDATA = 8'h18;
  localparam logic [7:0] A_FLVL = 8'h1C;
  localparam logic [7:0] A_WM = 8'h20;
  localparam logic [7:0] A_CTRL = 8'h24;
  localparam logic [7:0] A_MODE = 8'h28;
  localparam logic [7:0] A_CRC = 8'h2C;
  localparam logic [7:0] A_TMODE = 8'h30;
  localparam logic [7:0] A_TPRE = 8'h34;
  localparam logic [7:0] A_TRLD = 8'h38;
  localparam logic [7:0] A_TCNT = 8'h3C;
  localparam int B_SETSEL = 7;
  localparam int B_FLUSH = 7;
  localparam int B_STOP = 7;
  localparam int B_START = 6;
  localparam int B_MSB = 7;
  localparam int B_TIMER_AUTO_START = 7;
  localparam int B_TRST = 4;
  localparam int B_CRCF = 2;
  localparam int F_TMR = 0;
  localparam int F_ERR = 1;
  localparam int F_LO = 2;
  localparam int F_HI = 3;
  localparam int F_IDLE = 4;
  localparam int F_RX = 5;
  localparam int F_TX = 6;
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_CRC = 4'h3;
  localparam logic [5:0] WM_RST = 6'h08;
  localparam logic [1:0] PRE_RST = 2'h1;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_POLY_R = 16'h8408;
  localparam int TMR_CLK_KHZ = 6780;
  localparam int SYS_CLK_KHZ = 250000;
  localparam logic [14:0] TICK_STEP = 15'(TMR_CLK_KHZ / 10);
  localparam logic [14:0] TICK_WRAP = 15'(SYS_CLK_KHZ / 10);
endpackage : fitc_pkg

// *** verilog/fitc_core.sv ***
// register-mapped fifo, crc engine, interrupt flags and timer of the reader core
`timescale 1ns/1ps
`default_nettype none
module fitc_core
  import fitc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic SM_PUSH,
  input wire logic [7:0] SM_DATA,
  input wire logic TX_EOF,
  input wire logic RX_END,
  input wire logic CMD_DONE,
  input wire logic [3:0] ERR_IN,
  input wire logic TIMER_TRIGGER,
  output logic IRQ
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [5:0] wp;
    logic [5:0] rp;
    logic [6:0] cnt;
    logic ovf;
    logic [3:0] err;
    logic [3:0] cmd;
    logic [6:0] ien;
    logic cen;
    logic [6:0] fl;
    logic cfl;
    logic [5:0] wm;
    logic msb;
    logic [1:0] pre;
    logic [15:0] crc;
    logic crdy;
    logic timer_auto_start;
    logic trst;
    logic [3:0] phi;
    logic [7:0] plo;
    logic [15:0] rld;
    logic [15:0] tcnt;
    logic [11:0] pcnt;
    logic trun;
    logic [14:0] acc;
    logic hi_p;
    logic lo_p;
    logic wreq;
    logic [31:0] rdat;
    logic irq;
  } fitc_st_s;

  fitc_st_s st_q;
  fitc_st_s st_d;
  logic take;
  logic hwr;
  logic hrd;
  logic [7:0] wa;
  logic tick;
  logic flush;
  logic tstart;
  logic tstop;
  logic tset;

  function automatic logic [15:0] crc_preset(input logic [1:0] sel);
    unique case (sel)
      2'h0: crc_preset = 16'h0000;
      2'h1: crc_preset = 16'h6363;
      2'h2: crc_preset = 16'hA671;
      2'h3: crc_preset = 16'hFFFF;
    endcase
  endfunction : crc_preset

  // one byte per call, bit-serial inside
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b, input logic m);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (m)
      begin
        fb = r[15] ^ b[7-i];
        r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      else
      begin
        fb = r[0] ^ b[i];
        r = {1'b0, r[15:1]} ^ (fb ? CRC_POLY_R : 16'h0000);
      end
    end
    crc_byte = r;
  endfunction : crc_byte

  function automatic logic hi_alert(input logic [6:0] n, input logic [5:0] w);
    hi_alert = (7'(FIFO_DEPTH) - n) <= {1'b0, w};
  endfunction : hi_alert

  function automatic logic lo_alert(input logic [6:0] n, input logic [5:0] w);
    lo_alert = n <= {1'b0, w};
  endfunction : lo_alert

  always_comb
  begin
    logic [7:0] b;
    logic pop_h;
    logic pop_c;
    logic push_h;
    logic push_s;
    logic [6:0] set;
    logic [14:0] an;
    b = 8'h00;
    set = 7'h00;
    pop_h = 1'b0;
    pop_c = 1'b0;
    push_h = 1'b0;
    push_s = 1'b0;
    an = 15'h0000;
    st_d = st_q;
    take = (READ | WRITE) & st_q.wreq;
    hwr = take & WRITE;
    hrd = take & READ;
    wa = {ADDRESS[7:2], 2'b00};
    st_d.wreq = ~take;
    flush = hwr && wa == A_FLVL && WRITEDATA[B_FLUSH];
    push_h = hwr && wa == A_FDATA;
    push_s = SM_PUSH && !push_h;
    pop_h = hrd && wa == A_FDATA && st_q.cnt != 7'h00;
    pop_c = st_q.cmd == CMD_CRC && st_q.cnt != 7'h00 && !pop_h && !flush;
    st_d.err = ERR_IN;
    // fifo: flush first, then pop, then push on what is left
    if (flush)
    begin
      st_d.wp = 6'h00;
      st_d.rp = 6'h00;
      st_d.cnt = 7'h00;
      st_d.ovf = 1'b0;
    end
    else if (pop_h || pop_c)
    begin
      b = st_q.mem[st_q.rp];
      st_d.rp = st_q.rp + 6'h01;
      st_d.cnt = st_q.cnt - 7'h01;
    end
    if (push_h || (push_s && !flush))
    begin
      if (st_d.cnt == 7'(FIFO_DEPTH))
        st_d.ovf = 1'b1;
      else
      begin
        st_d.mem[st_d.wp] = push_h ? WRITEDATA[7:0] : SM_DATA;
        st_d.wp = st_d.wp + 6'h01;
        st_d.cnt = st_d.cnt + 7'h01;
      end
    end
    // crc engine drains the fifo while its command is active
    if (pop_c)
    begin
      st_d.crc = crc_byte(st_q.crc, b, st_q.msb);
      st_d.crdy = 1'b0;
    end
    else if (st_q.cmd == CMD_CRC && st_q.cnt == 7'h00)
      st_d.crdy = 1'b1;
    if (CMD_DONE && st_q.cmd != CMD_IDLE)
    begin
      st_d.cmd = CMD_IDLE;
      set[F_IDLE] = 1'b1;
    end
    if (hwr && wa == A_CMD)
    begin
      st_d.cmd = WRITEDATA[3:0];
      if (WRITEDATA[3:0] == CMD_CRC)
      begin
        st_d.crc = crc_preset(st_q.pre);
        st_d.crdy = 1'b0;
      end
    end
    // timer: fractional divider makes the 6.78 MHz step
    an = st_q.acc + TICK_STEP;
    tick = an >= TICK_WRAP;
    st_d.acc = tick ? an - TICK_WRAP : an;
    tstart = (hwr && wa == A_CTRL && WRITEDATA[B_START]) || (TIMER_TRIGGER && st_q.timer_auto_start);
    tstop = hwr && wa == A_CTRL && WRITEDATA[B_STOP];
    tset = 1'b0;
    if (tstop)
      st_d.trun = 1'b0;
    else if (tstart)
    begin
      st_d.trun = 1'b1;
      st_d.tcnt = st_q.rld;
      st_d.pcnt = {st_q.phi, st_q.plo};
    end
    else if (st_q.trun && tick)
    begin
      if (st_q.pcnt == 12'h000)
      begin
        st_d.pcnt = {st_q.phi, st_q.plo};
        if (st_q.tcnt == 16'h0000)
        begin
          if (st_q.trst)
            st_d.tcnt = st_q.rld;
          else
            st_d.trun = 1'b0;
        end
        else
        begin
          st_d.tcnt = st_q.tcnt - 16'h0001;
          tset = st_q.tcnt == 16'h0001;
        end
      end
      else
        st_d.pcnt = st_q.pcnt - 12'h001;
    end
    // expiry only raises a flag and touches nothing else
    set[F_TMR] = tset;
    set[F_ERR] = st_d.ovf || st_d.err != 4'h0;
    // watermark lands before the alerts so status never lags the new threshold
    if (hwr && wa == A_WM)
      st_d.wm = WRITEDATA[5:0];
    st_d.hi_p = hi_alert(st_d.cnt, st_d.wm);
    st_d.lo_p = lo_alert(st_d.cnt, st_d.wm);
    set[F_HI] = st_d.hi_p && !st_q.hi_p;
    set[F_LO] = st_d.lo_p && !st_q.lo_p;
    set[F_RX] = RX_END;
    set[F_TX] = TX_EOF;
    // host set/clear first; hardware sets win in the same cycle
    if (hwr && wa == A_IFL)
    begin
      if (WRITEDATA[B_SETSEL])
        st_d.fl = st_q.fl | WRITEDATA[6:0];
      else
        st_d.fl = st_q.fl & ~WRITEDATA[6:0];
    end
    st_d.fl = st_d.fl | set;
    if (hwr && wa == A_IFM)
      st_d.cfl = WRITEDATA[B_SETSEL] ? st_q.cfl | WRITEDATA[B_CRCF] : st_q.cfl & ~WRITEDATA[B_CRCF];
    if (st_d.crdy && !st_q.crdy)
      st_d.cfl = 1'b1;
    if (hwr)
    begin
      unique case (wa)
        A_IEN:
        begin
          st_d.ien = WRITEDATA[6:0];
          st_d.cen = WRITEDATA[8];
        end
        A_MODE:
        begin
          st_d.msb = WRITEDATA[B_MSB];
          st_d.pre = WRITEDATA[1:0];
        end
        A_TMODE:
        begin
          st_d.timer_auto_start = WRITEDATA[B_TIMER_AUTO_START];
          st_d.trst = WRITEDATA[B_TRST];
          st_d.phi = WRITEDATA[3:0];
        end
        A_TPRE: st_d.plo = WRITEDATA[7:0];
        A_TRLD: st_d.rld = WRITEDATA[15:0];
        default: ;
      endcase
    end
    if (hrd)
    begin
      unique case (wa)
        A_CMD: st_d.rdat = {28'h0, st_q.cmd};
        A_IEN: st_d.rdat = {23'h0, st_q.cen, 1'b0, st_q.ien};
        A_IFL: st_d.rdat = {25'h0, st_q.fl};
        A_IFM: st_d.rdat = {29'h0, st_q.cfl, 2'h0};
        A_ERR: st_d.rdat = {27'h0, st_q.ovf, st_q.err};
        A_STAT: st_d.rdat = {26'h0, st_q.crdy, st_q.irq, st_q.trun, 1'b0, st_q.hi_p, st_q.lo_p};
        A_FDATA: st_d.rdat = {24'h0, b};
        A_FLVL: st_d.rdat = {25'h0, st_q.cnt};
        A_WM: st_d.rdat = {26'h0, st_q.wm};
        A_MODE: st_d.rdat = {24'h0, st_q.msb, 5'h0, st_q.pre};
        A_CRC: st_d.rdat = {16'h0, st_q.crc};
        A_TMODE: st_d.rdat = {24'h0, st_q.timer_auto_start, 2'h0, st_q.trst, st_q.phi};
        A_TPRE: st_d.rdat = {24'h0, st_q.plo};
        A_TRLD: st_d.rdat = {16'h0, st_q.rld};
        A_TCNT: st_d.rdat = {16'h0, st_q.tcnt};
        default: st_d.rdat = 32'h0;
      endcase
    end
    st_d.irq = |(st_d.fl & st_d.ien) || (st_d.cfl && st_d.cen);
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q <= '0;
      st_q.wreq <= 1'b1;
      st_q.wm <= WM_RST;
      st_q.pre <= PRE_RST;
      st_q.lo_p <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign READDATA = st_q.rdat;
  assign WAITREQUEST = st_q.wreq;
  assign IRQ = st_q.irq;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  property p_level;
    st_q.cnt <= 7'(FIFO_DEPTH);
  endproperty
  a_level: assert property (p_level) else $error("fifo level above depth");

  property p_flush;
    flush |=> st_q.cnt == 7'h00 && !st_q.ovf && st_q.rp == 6'h00;
  endproperty
  a_flush: assert property (p_flush) else $error("flush did not empty fifo");

  property p_ovf_hold;
    st_q.ovf && !flush |=> st_q.ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow cleared without flush");

  property p_hi_alert;
    st_q.hi_p == ((7'(FIFO_DEPTH) - st_q.cnt) <= {1'b0, st_q.wm});
  endproperty
  a_hi_alert: assert property (p_hi_alert) else $error("almost full status wrong");

  property p_irq;
    IRQ == (|(st_q.fl & st_q.ien) || (st_q.cfl && st_q.cen));
  endproperty
  a_irq: assert property (p_irq) else $error("irq pin disagrees with flags");

  property p_timer_flag;
    st_q.trun && tick && st_q.pcnt == 12'h000 && st_q.tcnt == 16'h0001 && !tstart && !tstop
      |=> st_q.fl[F_TMR] && st_q.tcnt == 16'h0000;
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("timer flag missed at 1 to 0");

  property p_restart;
    st_q.trun && tick && st_q.pcnt == 12'h000 && st_q.tcnt == 16'h0000 && st_q.trst && !tstart && !tstop
      |=> st_q.trun && st_q.tcnt == $past(st_q.rld);
  endproperty
  a_restart: assert property (p_restart) else $error("timer did not restart from reload");

  property p_err_flag;
    ERR_IN != 4'h0 |=> st_q.fl[F_ERR];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not set by error bits");

  property p_tx;
    TX_EOF |=> st_q.fl[F_TX];
  endproperty
  a_tx: assert property (p_tx) else $error("transmit flag not set");

  property p_crc_done;
    st_q.cmd == CMD_CRC && st_q.cnt == 7'h00 && !hwr |=> st_q.crdy;
  endproperty
  a_crc_done: assert property (p_crc_done) else $error("crc ready missing");

  // the flag rises with ready; a later host clear is legal, so only the rising edge is checked
  property p_crc_flag;
    $rose(st_q.crdy) |-> st_q.cfl;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc done flag missing at ready");

  property p_stop;
    tstop |=> !st_q.trun ##1 (!st_q.trun || $past(tstart));
  endproperty
  a_stop: assert property (p_stop) else $error("timer still running after stop");

  property p_answer;
    take |=> !WAITREQUEST ##1 WAITREQUEST;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");

  c_overflow: cover property (st_q.ovf);
  c_crc: cover property (st_q.cfl && st_q.crdy);
  c_timer: cover property (st_q.fl[F_TMR] && !st_q.trun);
  c_irq: cover property ($rose(IRQ));
  c_flush: cover property (flush && st_q.ovf);
endmodule : fitc_core
`default_nettype wire

// *** sim/fitc_host.sv ***
// avalon-mm master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module fitc_host
(
  input wire logic clk,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  output logic hung
);
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    hung = 1'b0;
  end

  // one whole access; flags are cleared only by writes, never by reads
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
      hung <= 1'b1;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // released address shows a changing pattern, not the last value
    address <= ~a;
  endtask : access
endmodule : fitc_host
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the fifo, crc, interrupt and timer core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fitc_pkg::*;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] ADDRESS;
  logic READ, WRITE, WAITREQUEST, IRQ, hung;
  logic [31:0] WRITEDATA, READDATA;
  logic SM_PUSH = 1'b0;
  logic [7:0] SM_DATA = 8'h00;
  logic [3:0] ev = 4'h0;
  logic [3:0] ERR_IN = 4'h0;
  int fails = 0;
  int comparisons = 0;
  integer seed = 32'hf59c;
  always #2 SYS_CLK = ~SYS_CLK;
  fitc_core i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .SM_PUSH(SM_PUSH), .SM_DATA(SM_DATA),
    .TX_EOF(ev[0]), .RX_END(ev[1]), .CMD_DONE(ev[2]), .ERR_IN(ERR_IN), .TIMER_TRIGGER(ev[3]), .IRQ(IRQ));
  fitc_host i_host (.clk(SYS_CLK), .address(ADDRESS), .read(READ), .write(WRITE), .writedata(WRITEDATA),
    .readdata(READDATA), .waitrequest(WAITREQUEST), .hung(hung));

  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  always @(posedge hung)
  begin
    fails++;
    report_and_stop();
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] got);
    comparisons++;
    if (got !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.access(1'b1, a, d, q);
  endtask : wr

  task automatic chk_reg(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    i_host.access(1'b0, a, 32'h0, q);
    cmp(n, e, q & m);
  endtask : chk_reg

  task automatic chk_pin(input logic e);
    @(negedge SYS_CLK);
    cmp("irq pin", {31'h0, e}, {31'h0, IRQ});
  endtask : chk_pin

  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] q;
    q = 32'h0;
    for (int i = 0; i < 600 && q[b] !== 1'b1; i++)
      i_host.access(1'b0, a, 32'h0, q);
    if (q[b] !== 1'b1)
    begin
      fails++;
      $display("Error poll %h expected 1 seen %b", a, q[b]);
      report_and_stop();
    end
  endtask : poll

  task automatic pulse(input int k);
    @(posedge SYS_CLK);
    ev[k] <= 1'b1;
    @(posedge SYS_CLK);
    ev[k] <= 1'b0;
  endtask : pulse

  function automatic logic [15:0] crc_of(input logic [1:0] s, input logic m, input logic [31:0] w);
    logic [15:0] c;
    c = (s == 2'h0) ? 16'h0000 : (s == 2'h1) ? 16'h6363 : (s == 2'h2) ? 16'hA671 : 16'hFFFF;
    for (int i = 0; i < 32; i++)
      if (m)
        c = (c[15] ^ w[(i / 8) * 8 + 7 - i % 8]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
      else
        c = (c[0] ^ w[i]) ? (c >> 1) ^ CRC_POLY_R : c >> 1;
    return c;
  endfunction : crc_of

  initial
  begin
    logic [7:0] mem [64];
    logic [31:0] w;
    logic [3:0] e;
    int wm, t0, c, ex;
    repeat (4) @(posedge SYS_CLK);
    NRST <= 1'b1;
    chk_reg("watermark", A_WM, 32'hFF, 32'h08);
    chk_reg("mode", A_MODE, 32'hFF, 32'h01);
    chk_reg("status", A_STAT, 32'h3F, 32'h01);
    chk_reg("flags", A_IFL, 32'hFF, 32'h00);
    wr(8'hFC, 32'hFF);
    chk_reg("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
    // fill to overflow, then drain, watching both alerts at every level
    wm = 4 + ($random(seed) & 15);
    wr(A_WM, wm);
    wr(A_IEN, 32'h0C);
    for (int i = 1; i <= 64; i++)
    begin
      mem[i - 1] = $random(seed);
      wr(A_FDATA, mem[i - 1]);
      chk_reg("alerts", A_STAT, 32'h3, 32'({(64 - i) <= wm, i <= wm}));
    end
    wr(A_FDATA, 32'h5A);
    chk_reg("level", A_FLVL, 32'h7F, 32'd64);
    chk_reg("overflow", A_ERR, 32'h10, 32'h10);
    chk_reg("hi flag", A_IFL, 32'h0C, 32'h08);
    chk_pin(1'b1);
    wr(A_IFL, 32'h7F);
    chk_pin(1'b0);
    for (int i = 0; i < 64; i++)
    begin
      chk_reg("fifo data", A_FDATA, 32'hFF, 32'(mem[i]));
      chk_reg("alerts", A_STAT, 32'h3, 32'({(i + 1) <= wm, (63 - i) <= wm}));
    end
    chk_reg("empty read", A_FDATA, 32'hFFFFFFFF, 32'h0);
    chk_reg("overflow held", A_ERR, 32'h10, 32'h10);
    chk_reg("lo flag", A_IFL, 32'h0C, 32'h04);
    chk_pin(1'b1);
    wr(A_FLVL, 32'h80);
    chk_reg("level flushed", A_FLVL, 32'h7F, 32'h0);
    chk_reg("overflow flushed", A_ERR, 32'h10, 32'h0);
    // event inputs and the error path
    wr(A_IEN, 32'h7F);
    wr(A_IFL, 32'h7F);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        wr(A_CMD, CMD_CRC);
      pulse(k);
      chk_reg("event flag", A_IFL, 32'h70, 32'h40 >> k);
      chk_pin(1'b1);
      wr(A_IFL, 32'h7F);
      chk_pin(1'b0);
    end
    chk_reg("command", A_CMD, 32'hF, 32'(CMD_IDLE));
    e = $random(seed) | 1;
    @(posedge SYS_CLK);
    ERR_IN <= e;
    chk_reg("error bits", A_ERR, 32'hF, 32'(e));
    wr(A_IFL, 32'h02);
    chk_reg("error flag", A_IFL, 32'h02, 32'h02);
    ERR_IN <= 4'h0;
    wr(A_IFL, 32'h7F);
    wr(A_IEN, 32'h0);
    wr(A_IFL, 32'h81);
    chk_reg("timer flag set", A_IFL, 32'h7F, 32'h01);
    chk_pin(1'b0);
    @(posedge SYS_CLK);
    SM_DATA <= 8'hC3;
    SM_PUSH <= 1'b1;
    @(posedge SYS_CLK);
    SM_PUSH <= 1'b0;
    chk_reg("core push", A_FLVL, 32'h7F, 32'h1);
    chk_reg("core byte", A_FDATA, 32'hFF, 32'hC3);
    // every preset and both bit orders
    for (int s = 0; s < 8; s++)
    begin
      w = $random(seed);
      wr(A_IFM, 32'h7F);
      for (int i = 0; i < 4; i++)
        wr(A_FDATA, w[8 * i +: 8]);
      wr(A_MODE, 32'((s / 4) * 128 + s % 4));
      wr(A_CMD, CMD_CRC);
      poll(A_IFM, B_CRCF);
      chk_reg("crc ready", A_STAT, 32'h20, 32'h20);
      chk_reg("crc", A_CRC, 32'hFFFF, 32'(crc_of(s % 4, s / 4, w)));
      wr(A_CMD, CMD_IDLE);
    end
    // one shot: prescaler 2, reload 3
    wr(A_FDATA, 32'hA5);
    wr(A_TPRE, 32'h2);
    wr(A_TMODE, 32'h0);
    wr(A_TRLD, 32'h3);
    wr(A_IFL, 32'h7F);
    wr(A_CTRL, 32'h40);
    t0 = $time;
    chk_reg("running", A_STAT, 32'h08, 32'h08);
    poll(A_IFL, F_TMR);
    c = ($time - t0) / 4;
    ex = 3 * 3 * 25000 / 678;
    cmp("timer delay", 32'h1, 32'(c > ex - 45 && c < ex + 45));
    repeat (300) @(posedge SYS_CLK);
    chk_reg("stopped", A_STAT, 32'h08, 32'h0);
    chk_reg("count", A_TCNT, 32'hFFFF, 32'h0);
    chk_reg("fifo kept", A_FLVL, 32'h7F, 32'h1);
    // auto start with restart, then stop now
    wr(A_TMODE, 32'h90);
    wr(A_IFL, 32'h7F);
    pulse(3);
    chk_reg("auto start", A_STAT, 32'h08, 32'h08);
    poll(A_IFL, F_TMR);
    wr(A_IFL, 32'h01);
    poll(A_IFL, F_TMR);
    chk_reg("restarted", A_STAT, 32'h08, 32'h08);
    wr(A_CTRL, 32'h80);
    chk_reg("stop now", A_STAT, 32'h08, 32'h0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
